// *** verilog/smwc_top.sv ***
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "smwc_consts.svh"
module smwc_top #(
  parameter int unsigned LONG_CYC = `SMWC_LONG_CYC
) (
  input  wire logic                sys_clk_i,            // 25 MHz clock
  input  wire logic                rst_i,                // Async reset, active high
  input  wire logic                psel_i,               // APB select
  input  wire logic                penable_i,            // APB enable
  input  wire logic                pwrite_i,             // APB write
  input  wire logic [11:0]         paddr_i,              // APB byte address
  input  wire logic [31:0]         pwdata_i,             // APB write data
  output logic      [31:0]         prdata_o,             // APB read data
  output logic                     pready_o,             // APB ready
  output logic                     pslverr_o,            // APB error, unmapped
  input  wire logic                sleep_instr_i,        // Sleep instruction pulse
  input  wire smwc_pkg::smwc_wake_t wake_i,              // Wake sources, async
  input  wire smwc_pkg::smwc_periph_t periph_en_i,       // Peripheral enables
  input  wire logic [3:0]          clock_source_fuses_i, // Fuse levels
  input  wire logic                por_ok_i,             // Supply above threshold
  output smwc_pkg::smwc_clk_t      clk_en_o,             // Clock domain enables
  output smwc_pkg::smwc_periph_t   periph_run_o,         // Peripheral run enables
  output logic                     adc_start_o,          // Conversion start pulse
  output logic                     int_reset_o,          // Internal reset
  output logic                     sleeping_o            // Not in run state
);
  import smwc_pkg::*;

  smwc_state_t  state_q;
  smwc_wake_t   wake_s;
  smwc_wake_t   cause_q;
  logic [3:0]   ctrl_q;
  logic [3:0]   fuse_s;
  logic         por_s;
  logic         por_d_q;
  logic         por_wait_q;
  logic         bad_mode_q;
  logic [2:0]   last_mode_q;
  logic         dly_busy;
  logic         dly_done;
  logic [19:0]  dly_load;
  logic         dly_start;
  logic         sleep_go;
  logic         wake_hit;
  logic         apb_acc;
  logic         por_lost_w;
  logic [`SMWC_NSYNC-1:0] raw_w;
  logic [`SMWC_NSYNC-1:0] sync_w;

  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      `SMWC_OFS_CTRL: reg_sel = 2'h0;
      `SMWC_OFS_STAT: reg_sel = 2'h1;
      `SMWC_OFS_WAKE: reg_sel = 2'h2;
      default:        reg_sel = 2'h3;
    endcase
  endfunction : reg_sel

  function automatic smwc_clk_t clk_of(input smwc_state_t s);
    smwc_clk_t c;
    c = '{default: 1'b1};
    case (s)
      ST_IDLE:  begin
        c.cpu   = 1'b0; // [R01]
        c.flash = 1'b0;
      end
      ST_ADCNR: begin
        c.cpu   = 1'b0; // [R05]
        c.flash = 1'b0;
        c.io    = 1'b0;
      end
      ST_PDOWN: c = '{async: 1'b1, default: 1'b0}; // [R08]
      ST_WAKE:  c = '{osc: 1'b1, async: 1'b1, default: 1'b0}; // [R12]
      default:  c = '{default: 1'b1};
    endcase
    clk_of = c;
  endfunction : clk_of

  function automatic smwc_periph_t allow_of(input smwc_state_t s);
    smwc_periph_t p;
    p = '{default: 1'b1}; // [R02]
    case (s)
      ST_ADCNR: p = '{adc: 1'b1, irq: 1'b1, universal_serial_interface: 1'b1, tmr2: 1'b1,
                      lcd: 1'b1, wdt: 1'b1, default: 1'b0}; // [R06]
      ST_PDOWN, ST_WAKE:
                p = '{irq: 1'b1, universal_serial_interface: 1'b1, wdt: 1'b1, default: 1'b0}; // [R09]
      default:  p = '{default: 1'b1};
    endcase
    allow_of = p;
  endfunction : allow_of

  function automatic smwc_wake_t wmask_of(input smwc_state_t s);
    smwc_wake_t m;
    m = '{default: 1'b0};
    case (s)
      ST_IDLE:  m = '{default: 1'b1}; // [R03]
      ST_ADCNR: m = '{ext_int: 1'b0, other_irq: 1'b0, default: 1'b1}; // [R07]
      ST_PDOWN: m = '{ext_rst: 1'b1, wdt_rst: 1'b1, bod_rst: 1'b1, start_cond: 1'b1,
                      level_ext_interrupt_zero: 1'b1, pin_change: 1'b1, default: 1'b0}; // [R10]
      default:  m = '{default: 1'b0};
    endcase
    wmask_of = m;
  endfunction : wmask_of

  // Wake, fuse and supply levels see two flops before any logic, except the supply-loss reset
  assign raw_w = {por_ok_i, clock_source_fuses_i, wake_i};
  for (genvar gi = 0; gi < `SMWC_NSYNC; gi++) begin : g_sync
    logic meta_q;
    logic sync_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= raw_w[gi];
        sync_q <= meta_q;
      end
    end
    assign sync_w[gi] = sync_q;
  end
  assign wake_s = smwc_wake_t'(sync_w[11:0]);
  assign fuse_s = sync_w[15:12];
  assign por_s  = sync_w[16];

  // Level wake sources are not latched; the source must hold them [R11]
  assign wake_hit  = |(wake_s & wmask_of(state_q));
  assign sleep_go  = sleep_instr_i && ctrl_q[`SMWC_CTRL_SE_BIT] && state_q == ST_RUN
                     && !int_reset_o;
  assign dly_load  = fuse_s[`SMWC_FUSE_LONG_BIT] ? 20'(LONG_CYC)
                                                 : 20'(`SMWC_SHORT_CYC); // [R12]
  assign dly_start = (por_s && !por_d_q) ||
                     (state_q == ST_PDOWN && wake_hit && !int_reset_o); // [R13]

  smwc_delay u_delay (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (dly_start),
    .load_i    (dly_load),
    .busy_o    (dly_busy),
    .done_o    (dly_done)
  );

  // Supply loss bypasses the synchroniser so reset cannot lag the drop
  assign por_lost_w = rst_i || !por_ok_i;
  always_ff @(posedge sys_clk_i or posedge por_lost_w) begin
    if (por_lost_w) begin
      int_reset_o <= 1'b1; // [R14]
    end else if (por_wait_q && dly_done) begin
      int_reset_o <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_d_q    <= 1'b0;
      por_wait_q <= 1'b0;
    end else begin
      por_d_q <= por_s;
      if (por_s && !por_d_q) begin
        por_wait_q <= 1'b1; // [R13]
      end else if (dly_done || !por_s) begin
        por_wait_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else if (int_reset_o) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (sleep_go) begin
            case (ctrl_q[2:0])
              `SMWC_SMS_IDLE:  state_q <= ST_IDLE;  // [R01]
              `SMWC_SMS_ADCNR: state_q <= ST_ADCNR; // [R05]
              `SMWC_SMS_PDOWN: state_q <= ST_PDOWN; // [R08]
              default:         state_q <= ST_RUN;   // [R16]
            endcase
          end
        end
        ST_IDLE, ST_ADCNR: begin
          if (wake_hit) begin
            state_q <= ST_RUN; // [R15]
          end
        end
        ST_PDOWN: begin
          if (wake_hit) begin
            state_q <= ST_WAKE; // [R12]
          end
        end
        ST_WAKE: begin
          if (dly_done) begin
            state_q <= ST_RUN; // [R15]
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_en_o     <= '{default: 1'b1};
      periph_run_o <= '{default: 1'b0};
      adc_start_o  <= 1'b0;
      sleeping_o   <= 1'b0;
    end else begin
      clk_en_o     <= clk_of(state_q);
      periph_run_o <= allow_of(state_q) & periph_en_i;
      adc_start_o  <= sleep_go && periph_en_i.adc && (ctrl_q[2:0] == `SMWC_SMS_IDLE ||
                      ctrl_q[2:0] == `SMWC_SMS_ADCNR); // [R04]
      sleeping_o   <= state_q != ST_RUN;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q     <= '{default: 1'b0};
      last_mode_q <= 3'h0;
    end else if (sleep_go) begin
      cause_q     <= '{default: 1'b0};
      last_mode_q <= ctrl_q[2:0];
    end else if (wake_hit && state_q != ST_RUN && state_q != ST_WAKE) begin
      cause_q <= wake_s & wmask_of(state_q);
    end
  end

  // APB: one wait state, answer registered
  assign apb_acc = psel_i && penable_i && pready_o;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && reg_sel(paddr_i) == 2'h3;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        case (reg_sel(paddr_i))
          2'h0:    prdata_o <= {28'h0000000, ctrl_q};
          2'h1:    prdata_o <= {20'h00000, last_mode_q, bad_mode_q, 1'b0, por_wait_q,
                                int_reset_o, state_q};
          2'h2:    prdata_o <= {20'h00000, cause_q};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `SMWC_CTRL_RST;
    end else if (apb_acc && pwrite_i && reg_sel(paddr_i) == 2'h0) begin
      ctrl_q <= pwdata_i[3:0];
    end
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bad_mode_q <= 1'b0;
    end else if (sleep_go && ctrl_q[2:0] > `SMWC_SMS_PDOWN) begin
      bad_mode_q <= 1'b1; // [R16]
    end else if (apb_acc && pwrite_i && reg_sel(paddr_i) == 2'h1 &&
                 pwdata_i[`SMWC_STAT_CLR_BIT]) begin
      bad_mode_q <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_enter(logic [2:0] m);
    sleep_go && ctrl_q[2:0] == m;
  endsequence
  sequence s_pd_wake;
    state_q == ST_PDOWN && wake_hit && !int_reset_o;
  endsequence

  chk_idle_entry: assert property (s_enter(3'h0) |=> state_q == ST_IDLE) // [R01]
    else $error("idle not entered");
  chk_idle_clocks: assert property (state_q == ST_IDLE |=> !clk_en_o.cpu && !clk_en_o.flash
    && clk_en_o.io && clk_en_o.osc) // [R01]
    else $error("idle clock gating wrong");
  chk_adcnr_clocks: assert property (state_q == ST_ADCNR |=> !clk_en_o.io && !clk_en_o.cpu
    && clk_en_o.adc) // [R05]
    else $error("adc noise clocks wrong");
  chk_pdown_clocks: assert property (s_enter(3'h2) ##1 state_q == ST_PDOWN |=>
    !clk_en_o.osc && !clk_en_o.io && clk_en_o.async) // [R08]
    else $error("power-down clocks wrong");
  chk_adc_autostart: assert property (s_enter(3'h1) ##0 periph_en_i.adc |=> adc_start_o ##1
    !adc_start_o) // [R04]
    else $error("adc start pulse wrong");
  chk_pd_wake_delay: assert property (s_pd_wake |=> state_q == ST_WAKE ##1
    (state_q == ST_WAKE || int_reset_o)) // [R12]
    else $error("power-down wake skipped delay");
  chk_wake_hold: assert property (state_q == ST_WAKE && !dly_done && !int_reset_o |->
    dly_busy ##1 (state_q == ST_WAKE && !clk_en_o.cpu)) // [R15]
    else $error("resumed before delay end");
  chk_pd_no_wake: assert property (state_q == ST_PDOWN && !wake_hit && !int_reset_o
    && por_ok_i |=> state_q == ST_PDOWN) // [R10]
    else $error("illegal power-down wake");
  chk_por_hold: assert property (por_wait_q && !dly_done |=> int_reset_o) // [R13]
    else $error("reset released early");
  chk_por_drop: assert property (!por_ok_i |=> int_reset_o && state_q == ST_RUN) // [R14]
    else $error("reset not reasserted");
  chk_bad_mode: assert property (sleep_go && ctrl_q[2:0] > 3'h2 |=> state_q == ST_RUN
    && bad_mode_q) // [R16]
    else $error("undefined mode slept");
endmodule : smwc_top

// *** verilog/smwc_consts.svh ***
`ifndef SMWC_CONSTS_SVH
`define SMWC_CONSTS_SVH
// How it works
// (R01) Sleep with mode 000 enters Idle: CPU and flash clocks stop, others run.
// (R02) Idle keeps LCD, SPI, USART, comparator, ADC, serial, timers, watchdog, interrupts running.
// (R03) Idle wakes on any external or internal interrupt source.
// (R04) Entering Idle or ADC noise reduction with ADC enabled starts a conversion.
// (R05) Sleep with mode 001 enters ADC noise reduction: I/O, CPU, flash clocks stop.
// (R06) ADC noise reduction keeps enabled ADC, ext irq, start detect, timer2, LCD, watchdog.
// (R07) ADC noise reduction wakes only on its listed resets and interrupts.
// (R08) Sleep with mode 010 enters power-down: oscillator and generated clocks stop.
// (R09) Power-down keeps enabled external interrupts, start detect and watchdog running.
// (R10) Power-down wakes only on resets, start condition, level int zero, pin change.
// (R11) A level wake source must hold its level until the wake is seen.
// (R12) Power-down wake waits a start-up delay chosen by the clock source fuses.
// (R13) Supply reaching threshold starts a delay counter; reset holds until it expires.
// (R14) Supply falling below threshold reasserts internal reset at once.
// (R15) A valid wake re-enables clocks and resumes after any start-up delay.
// (R16) Undefined mode codes do not sleep; they are flagged and ignored.

`define SMWC_CLK_MHZ        25
`define SMWC_OFS_CTRL       12'h000
`define SMWC_OFS_STAT       12'h004
`define SMWC_OFS_WAKE       12'h008
`define SMWC_CTRL_SE_BIT    3
`define SMWC_CTRL_RST       4'h0
`define SMWC_STAT_CLR_BIT   8
`define SMWC_SMS_IDLE       3'h0
`define SMWC_SMS_ADCNR      3'h1
`define SMWC_SMS_PDOWN      3'h2
`define SMWC_FUSE_LONG_BIT  3
`define SMWC_START_SHORT_US 64
`define SMWC_START_LONG_US  4100
`define SMWC_SHORT_CYC      (`SMWC_START_SHORT_US * `SMWC_CLK_MHZ)
`define SMWC_LONG_CYC       (`SMWC_START_LONG_US * `SMWC_CLK_MHZ)
`define SMWC_NSYNC          17
`endif

// *** verilog/smwc_pkg.sv ***
package smwc_pkg;
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_IDLE  = 5'h02,
    ST_ADCNR = 5'h04,
    ST_PDOWN = 5'h08,
    ST_WAKE  = 5'h10
  } smwc_state_t;

  typedef struct packed {
    logic osc;
    logic async;
    logic adc;
    logic io;
    logic flash;
    logic cpu;
  } smwc_clk_t;

  typedef struct packed {
    logic lcd;
    logic spi;
    logic usart;
    logic acomp;
    logic adc;
    logic universal_serial_interface;
    logic timers;
    logic tmr2;
    logic wdt;
    logic irq;
  } smwc_periph_t;

  typedef struct packed {
    logic ext_rst;
    logic wdt_rst;
    logic bod_rst;
    logic ext_int;
    logic level_ext_interrupt_zero;
    logic pin_change;
    logic start_cond;
    logic adc_done;
    logic lcd_irq;
    logic tmr2_irq;
    logic mem_ready;
    logic other_irq;
  } smwc_wake_t;
endpackage : smwc_pkg

// *** verilog/smwc_delay.sv ***
`timescale 1ns/1ps
module smwc_delay (
  input  wire logic        sys_clk_i, // System clock
  input  wire logic        rst_i,     // Async reset, active high
  input  wire logic        start_i,   // Load and start counting
  input  wire logic [19:0] load_i,    // Cycles to wait, at least one
  output logic             busy_o,    // Counting
  output logic             done_o     // One-cycle pulse at expiry
);
  logic [19:0] cnt_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 20'h00000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // Restart wins so a repeated trigger always waits a full period
        cnt_q  <= load_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_q <= 20'h00001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 20'h00001;
        end
      end
    end
  end
endmodule : smwc_delay

// *** tb/smwc_cpu_model.sv ***
`timescale 1ns/1ps
module smwc_cpu_model (
  input  wire logic           sys_clk_i,     // Clock
  input  wire logic           rst_i,         // Reset, active high
  input  wire logic           sleep_req_i,   // Issue one sleep instruction
  input  wire logic           wake_go_i,     // Raise the wake pattern
  input  wire logic [11:0]    wake_pat_i,    // Wake sources to raise
  output logic                sleep_instr_o, // Sleep instruction pulse
  output smwc_pkg::smwc_wake_t wake_o        // Wake source levels
);
  import smwc_pkg::*;
  logic [2:0] hold_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_instr_o <= 1'b0;
    end else begin
      sleep_instr_o <= sleep_req_i;
    end
  end

  // Held past the two-flop sync, else a level wake can be lost
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 3'h0;
      wake_o <= '0;
    end else if (wake_go_i) begin
      hold_q <= 3'h5;
      wake_o <= wake_pat_i;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      wake_o <= '0;
    end
  end
endmodule : smwc_cpu_model

// *** tb/sleep_mode_wake_controller_test.sv ***
`timescale 1ns/1ps
`include "smwc_consts.svh"
module sleep_mode_wake_controller_test;
  import smwc_pkg::*;
  localparam int unsigned LCYC = 50;
  logic         sys_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, por_ok = 1'b0;
  logic         sleep_req = 1'b0, wake_go = 1'b0;
  logic [11:0]  paddr = 12'h000, wake_pat = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [3:0]   fuses = 4'h8;
  logic         pready, pslverr, sleep_instr, adc_start, int_reset, sleeping, er;
  smwc_wake_t   wake;
  smwc_periph_t pen = '0, prun;
  smwc_clk_t    clk_en;
  int           num_errors = 0, samples_checked = 0, cyc = 0, adc_cnt = 0;

  smwc_top #(.LONG_CYC(LCYC)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sleep_instr_i(sleep_instr), .wake_i(wake),
    .periph_en_i(pen), .clock_source_fuses_i(fuses), .por_ok_i(por_ok), .clk_en_o(clk_en),
    .periph_run_o(prun), .adc_start_o(adc_start), .int_reset_o(int_reset),
    .sleeping_o(sleeping));

  smwc_cpu_model cpu_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req), .wake_go_i(wake_go),
    .wake_pat_i(wake_pat), .sleep_instr_o(sleep_instr), .wake_o(wake));

  always #20 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk_i) begin
    cyc++;
    if (adc_start === 1'b1) begin
      adc_cnt++;
    end
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // Only the bench timeout ends a hung wait
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic sleep_op();
    @(posedge sys_clk_i);
    sleep_req <= 1'b1;
    @(posedge sys_clk_i);
    sleep_req <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask : sleep_op

  task automatic raise_wake(input logic [11:0] p);
    wake_pat <= p;
    wake_go  <= 1'b1;
    @(posedge sys_clk_i);
    wake_go  <= 1'b0;
  endtask : raise_wake

  function automatic logic [5:0] exp_clk(input logic [2:0] m);
    return (m == 3'h0) ? 6'h3C : (m == 3'h1) ? 6'h38 : 6'h10;
  endfunction : exp_clk

  function automatic logic [9:0] exp_allow(input logic [2:0] m);
    return (m == 3'h0) ? 10'h3FF : (m == 3'h1) ? 10'h237 : 10'h013;
  endfunction : exp_allow

  function automatic logic [11:0] wake_mask(input logic [2:0] m);
    return (m == 3'h0) ? 12'hFFF : (m == 3'h1) ? 12'hEFE : 12'hEE0;
  endfunction : wake_mask

  initial begin
    int n, b, adc0, dly;
    logic [2:0] m;
    logic [9:0] pv;
    logic [11:0] wm;
    rd = $urandom(32'hEE27DE54);
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk("int_reset", int_reset, 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i);
      por_ok <= 1'b1;
      n = 0;
      while (int_reset !== 1'b0 && n < 500) begin
        @(posedge sys_clk_i);
        n++;
      end
      chk("por_min", n >= LCYC, 32'h1);
      chk("por_max", n <= LCYC + 8, 32'h1);
      if (i == 0) begin
        @(posedge sys_clk_i);
        por_ok <= 1'b0;
        #1 chk("por_drop", int_reset, 32'h1);
      end
    end
    apb(1'b1, 12'hFFC, 32'h0);
    chk("unmapped", er, 32'h1);
    for (int k = 0; k < 9; k++) begin
      m = 3'(k % 3);
      pv = 10'($urandom);
      if (k < 3) begin
        pv[5] = 1'b1;
      end
      pen   <= pv;
      // Last power-down pass uses the short start-up
      fuses <= ((k == 8) ? 4'h0 : 4'h8) | 4'($urandom & 7);
      dly = (k == 8) ? `SMWC_SHORT_CYC : LCYC;
      apb(1'b1, 12'h000, {28'h0, 1'b1, m});
      adc0 = adc_cnt;
      sleep_op();
      chk("sleeping", sleeping, 32'h1);
      chk("clk_en", clk_en, exp_clk(m));
      chk("periph_run", prun, exp_allow(m) & pv);
      chk("adc_start", adc_cnt - adc0, (m != 3'h2 && pv[5]) ? 1 : 0);
      raise_wake(12'h001);
      repeat (12) @(posedge sys_clk_i);
      chk("irq_filter", sleeping, m != 3'h0);
      if (m != 3'h0) begin
        wm = wake_mask(m);
        do b = $urandom_range(11, 0); while (wm[b] !== 1'b1);
        raise_wake(12'h001 << b);
        n = 1;
        while (sleeping !== 1'b0 && n < 2000) begin
          @(posedge sys_clk_i);
          n++;
        end
        chk("wake_min", n >= ((m == 3'h2) ? dly : 1), 32'h1);
        chk("wake_max", n <= ((m == 3'h2) ? dly + 10 : 10), 32'h1);
      end
      repeat (2) @(posedge sys_clk_i);
      chk("clk_run", clk_en, 6'h3F);
      apb(1'b0, `SMWC_OFS_WAKE, 32'h0);
      chk("wake_cause", rd, (m == 3'h0) ? 32'h1 : (32'h1 << b));
    end
    m = 3'($urandom_range(7, 3));
    apb(1'b1, 12'h000, {28'h0, 1'b1, m});
    sleep_op();
    chk("bad_mode_run", sleeping, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("bad_flag", rd[8], 32'h1);
    chk("state_run", rd[4:0], 32'h1);
    apb(1'b1, 12'h004, 32'h100);
    apb(1'b0, 12'h004, 32'h0);
    chk("flag_clear", rd[8], 32'h0);
    give_verdict();
  end
endmodule : sleep_mode_wake_controller_test
